/* File: hdl/ssi_encoder_params.svh */
// constants for the serial absolute encoder port
`ifndef SSI_ENCODER_PARAMS_SVH
`define SSI_ENCODER_PARAMS_SVH

`define POS_W 25
`define FIFO_DEPTH 16
`define SYS_CLK_HZ 50000000
`define ZERO_MIN_MS 100
`define ZERO_MIN_CYC ((`SYS_CLK_HZ / 1000) * `ZERO_MIN_MS)
`define MONO_US 20
`define MONO_CYC ((`SYS_CLK_HZ / 1000000) * `MONO_US)
`define JUMP_LIMIT 25'h0000100
// pin order {link clock, supply low, direction, zero}
`define PIN_RESET 4'ha
`define PIN_ZERO 0
`define PIN_DIR 1
`define PIN_SUPPLY 2
`define PIN_CLK 3
`define ALARM_RESET 2'h3
`define DATA_IDLE 1'b1

`endif

/* File: hdl/ssi_encoder_pkg.sv */
// types shared by the serial absolute encoder port
`include "ssi_encoder_params.svh"

package ssi_encoder_pkg;

  typedef struct packed {
    logic [`POS_W-1:0] count;
  } pos_word_t;

  typedef struct packed {
    logic turnSupplyFlagOut;
    logic jumpFlagOut;
  } alarm_t;

  typedef enum logic {
    LINK_WAIT = 1'b0,
    LINK_ARMED = 1'b1
  } link_state_t;

endpackage

/* File: hdl/ssi_absolute_encoder_port.sv */
// serial absolute encoder port: position fifo, pin inputs, zeroing, alarms, shift link
// Operation
// - the link clock is high while loop current enters the positive clock input.
// - data leaves on a pair, positive line high for one and negative line high for zero.
// - a zero input held high for at least 100 ms makes the present position the zero point.
// - the jump alarm is asserted while a jump in the position word is seen.
// - the multiturn alarm is asserted while the multiturn supply is below its level.
// - both alarm outputs are active low: low during the fault, high otherwise.
// - an open direction input reads high.
// - direction high counts up for clockwise rotation, low for counter-clockwise.
// - an open zero input reads low.
`timescale 1ns/1ps
`include "ssi_encoder_params.svh"

module position_fifo #(
  parameter int WIDTH = `POS_W,
  parameter int DEPTH = `FIFO_DEPTH
)(
  input wire logic clk_sys,
  input wire logic reset_n,
  input wire logic inValid,
  output logic inReady,
  input wire logic [WIDTH-1:0] inData,
  output logic outValid,
  input wire logic outReady,
  output logic [WIDTH-1:0] outData
);
  localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  localparam int CW = $clog2(DEPTH + 1);

  logic [WIDTH-1:0] memQ [DEPTH];
  logic [WIDTH-1:0] memD [DEPTH];
  logic [PW-1:0] wrPtrQ, wrPtrD, rdPtrQ, rdPtrD;
  logic [CW-1:0] countQ, countD;
  logic push, pop;

  function automatic logic [PW-1:0] nextPtr(input logic [PW-1:0] p);
    nextPtr = (p == PW'(DEPTH - 1)) ? '0 : p + PW'(1);
  endfunction

  assign inReady = (countQ != CW'(DEPTH));
  assign outValid = (countQ != '0);
  assign outData = memQ[rdPtrQ];
  assign push = inValid && inReady;
  assign pop = outValid && outReady;

  always_comb
  begin
    memD = memQ;
    wrPtrD = wrPtrQ;
    rdPtrD = rdPtrQ;
    countD = countQ;
    if (push)
    begin
      memD[wrPtrQ] = inData;
      wrPtrD = nextPtr(wrPtrQ);
    end
    if (pop)
    begin
      rdPtrD = nextPtr(rdPtrQ);
    end
    if (push && !pop)
    begin
      countD = countQ + CW'(1);
    end
    else if (pop && !push)
    begin
      countD = countQ - CW'(1);
    end
  end

  always_ff @(posedge clk_sys)
  begin
    if (!reset_n)
    begin
      wrPtrQ <= '0;
      rdPtrQ <= '0;
      countQ <= '0;
      for (int i = 0; i < DEPTH; i++)
      begin
        memQ[i] <= '0;
      end
    end
    else
    begin
      wrPtrQ <= wrPtrD;
      rdPtrQ <= rdPtrD;
      countQ <= countD;
      memQ <= memD;
    end
  end
endmodule

module ssi_absolute_encoder_port
  import ssi_encoder_pkg::*;
#(
  parameter int FIFO_DEPTH = `FIFO_DEPTH,
  parameter int ZERO_MIN_CYC = `ZERO_MIN_CYC,
  parameter int MONO_CYC = `MONO_CYC,
  parameter logic [`POS_W-1:0] JUMP_LIMIT = `JUMP_LIMIT
)(
  input wire logic clk_sys,
  input wire logic reset_n,
  input wire logic ssiLoopClk,
  output logic dataPos,
  output logic dataNeg,
  input wire logic zeroIn,
  input wire logic dirIn,
  input wire logic turnSupplyLow,
  input wire pos_word_t rawWord,
  input wire logic rawValid,
  output logic rawReady,
  output logic position_jump_alarm_n,
  output logic multiturn_supply_alarm_n
);
  localparam int ZW = $clog2(ZERO_MIN_CYC + 1);
  localparam int MW = $clog2(MONO_CYC + 1);
  localparam int BW = $clog2(`POS_W + 1);

  // pin inputs: three flops, a change counts once stages two and three agree
  logic [3:0] pinRaw, s1Q, s2Q, s3Q, pinQ, pinD;

  assign pinRaw = {ssiLoopClk, turnSupplyLow, dirIn, zeroIn};

  for (genvar i = 0; i < 4; i++)
  begin : g_pin
    assign pinD[i] = (s2Q[i] == s3Q[i]) ? s3Q[i] : pinQ[i];
  end

  // open direction reads high, open zero reads low, also before the first sample
  always_ff @(posedge clk_sys)
  begin
    if (!reset_n)
    begin
      s1Q <= `PIN_RESET;
      s2Q <= `PIN_RESET;
      s3Q <= `PIN_RESET;
      pinQ <= `PIN_RESET;
    end
    else
    begin
      s1Q <= pinRaw;
      s2Q <= s1Q;
      s3Q <= s2Q;
      pinQ <= pinD;
    end
  end

  // zeroing and position arithmetic
  logic [ZW-1:0] zeroCntQ, zeroCntD;
  logic [`POS_W-1:0] offsetQ, offsetD, lastRawQ, lastRawD, diff, mag;
  logic haveRawQ, haveRawD;
  alarm_t alarmQ, alarmD;
  pos_word_t fifoIn, fifoOut;
  logic take, zeroFire, fifoValid, fifoPop;

  assign take = rawValid && rawReady;
  // fires once per pulse, on the cycle the filtered level has been high long enough
  assign zeroFire = pinQ[`PIN_ZERO] && (zeroCntQ == ZW'(ZERO_MIN_CYC - 1));
  assign diff = rawWord.count - lastRawQ;
  assign mag = diff[`POS_W-1] ? (`POS_W)'(~diff + 1'b1) : diff;

  // raw counts rise clockwise; direction low mirrors them about the zero point
  always_comb
  begin
    fifoIn.count = pinQ[`PIN_DIR] ? rawWord.count - offsetQ
                                  : offsetQ - rawWord.count;
  end

  always_comb
  begin
    zeroCntD = zeroCntQ;
    offsetD = offsetQ;
    lastRawD = lastRawQ;
    haveRawD = haveRawQ;
    alarmD = alarmQ;
    if (!pinQ[`PIN_ZERO])
    begin
      zeroCntD = '0;
    end
    else if (zeroCntQ != ZW'(ZERO_MIN_CYC))
    begin
      zeroCntD = zeroCntQ + ZW'(1);
    end
    if (zeroFire)
    begin
      offsetD = haveRawQ ? lastRawQ : '0;
    end
    if (take)
    begin
      lastRawD = rawWord.count;
      haveRawD = 1'b1;
      // a step beyond the limit between samples means a lost track
      alarmD.jumpFlagOut = !(haveRawQ && (mag > JUMP_LIMIT));
    end
    alarmD.turnSupplyFlagOut = !pinQ[`PIN_SUPPLY];
  end

  always_ff @(posedge clk_sys)
  begin
    if (!reset_n)
    begin
      zeroCntQ <= '0;
      offsetQ <= '0;
      lastRawQ <= '0;
      haveRawQ <= 1'b0;
      alarmQ <= `ALARM_RESET;
    end
    else
    begin
      zeroCntQ <= zeroCntD;
      offsetQ <= offsetD;
      lastRawQ <= lastRawD;
      haveRawQ <= haveRawD;
      alarmQ <= alarmD;
    end
  end

  assign position_jump_alarm_n = alarmQ.jumpFlagOut;
  assign multiturn_supply_alarm_n = alarmQ.turnSupplyFlagOut;

  position_fifo #(
    .WIDTH($bits(pos_word_t)),
    .DEPTH(FIFO_DEPTH)
  ) u_fifo (
    .clk_sys(clk_sys),
    .reset_n(reset_n),
    .inValid(rawValid),
    .inReady(rawReady),
    .inData(fifoIn),
    .outValid(fifoValid),
    .outReady(fifoPop),
    .outData(fifoOut)
  );

  // link hand-off: the word and its toggle change only after the clock has idled
  // high for the monoflop time, so they stand still through any read that follows
  link_state_t stateQ, stateD;
  logic [MW-1:0] quietCntQ, quietCntD;
  pos_word_t wordQ, wordD;
  logic genQ, genD, arm;

  assign arm = (stateQ == LINK_WAIT) && pinQ[`PIN_CLK] && (quietCntQ == MW'(MONO_CYC - 1));
  // the fifo drains only at arm time, so a slow reader back-pressures the source
  assign fifoPop = arm && fifoValid;

  always_comb
  begin
    stateD = stateQ;
    quietCntD = quietCntQ;
    wordD = wordQ;
    genD = genQ;
    case (stateQ)
      LINK_WAIT:
      begin
        quietCntD = pinQ[`PIN_CLK] ? quietCntQ + MW'(1) : '0;
        if (arm)
        begin
          stateD = LINK_ARMED;
          quietCntD = '0;
          genD = ~genQ;
          // an empty fifo repeats the last word rather than stall the reader
          if (fifoValid)
          begin
            wordD = fifoOut;
          end
        end
      end
      LINK_ARMED:
      begin
        if (!pinQ[`PIN_CLK])
        begin
          stateD = LINK_WAIT;
        end
      end
      default:
      begin
        stateD = LINK_WAIT;
        quietCntD = '0;
      end
    endcase
  end

  always_ff @(posedge clk_sys)
  begin
    if (!reset_n)
    begin
      stateQ <= LINK_WAIT;
      quietCntQ <= '0;
      wordQ <= '0;
      genQ <= 1'b0;
    end
    else
    begin
      stateQ <= stateD;
      quietCntQ <= quietCntD;
      wordQ <= wordD;
      genQ <= genD;
    end
  end

  // link domain: falling edges of the loop clock, the first edge of a read
  logic rstS1Q, rstS2Q, seenQ, seenD, bitQ, bitD, bitNQ;
  logic [`POS_W-1:0] shiftQ, shiftD;
  logic [BW-1:0] leftQ, leftD;

  always_comb
  begin
    seenD = seenQ;
    shiftD = shiftQ;
    leftD = leftQ;
    bitD = bitQ;
    if (!rstS2Q)
    begin
      seenD = 1'b0;
      shiftD = '0;
      leftD = '0;
      bitD = `DATA_IDLE;
    end
    else if (genQ != seenQ)
    begin
      // first edge of a read: latch the word and present its msb
      seenD = genQ;
      shiftD = {wordQ.count[`POS_W-2:0], 1'b0};
      bitD = wordQ.count[`POS_W-1];
      leftD = BW'(`POS_W - 1);
    end
    else if (leftQ != '0)
    begin
      bitD = shiftQ[`POS_W-1];
      shiftD = {shiftQ[`POS_W-2:0], 1'b0};
      leftD = leftQ - BW'(1);
    end
    else
    begin
      bitD = `DATA_IDLE;
    end
  end

  // loop current into the positive input is a high clock, so a read opens on a fall
  always_ff @(negedge ssiLoopClk)
  begin
    rstS1Q <= reset_n;
    rstS2Q <= rstS1Q;
    seenQ <= seenD;
    shiftQ <= shiftD;
    leftQ <= leftD;
    bitQ <= bitD;
    bitNQ <= ~bitD;
  end

  assign dataPos = bitQ;
  assign dataNeg = bitNQ;
endmodule

/* File: dv/ssi_encoder_port_asserts.sv */
// pin-level checks for the encoder port
`timescale 1ns/1ps
`include "ssi_encoder_params.svh"
module ssi_encoder_port_asserts
  import ssi_encoder_pkg::*;
#(
  parameter logic [`POS_W-1:0] JUMP_LIMIT = `JUMP_LIMIT
)(
  input wire logic clk_sys,
  input wire logic reset_n,
  input wire logic ssiLoopClk,
  input wire logic dataPos,
  input wire logic dataNeg,
  input wire logic turnSupplyLow,
  input wire pos_word_t rawWord,
  input wire logic rawValid,
  input wire logic rawReady,
  input wire logic position_jump_alarm_n,
  input wire logic multiturn_supply_alarm_n
);
  logic [`POS_W-1:0] prev_q, prev_d, diff;
  logic seen_q, seen_d, take, big;
  default clocking @(posedge clk_sys);
  endclocking
  default disable iff (!reset_n);
  // wrapped difference, so a roll-over of the count is no jump
  always_comb
  begin
    take = rawValid && rawReady;
    diff = rawWord.count - prev_q;
    big = (diff[`POS_W-1] ? -diff : diff) > JUMP_LIMIT;
    prev_d = !reset_n ? '0 : take ? rawWord.count : prev_q;
    seen_d = reset_n && (seen_q || take);
  end
  always_ff @(posedge clk_sys)
  begin
    prev_q <= prev_d;
    seen_q <= seen_d;
  end
  a_pair_sys:
    assert property (dataNeg == !dataPos) else $error("data pair not complementary");
  a_hold_data:
    assert property (ssiLoopClk && $past(ssiLoopClk) |-> $stable(dataPos))
    else $error("data moved while clock high");
  a_supply_low:
    assert property (turnSupplyLow [*7] |-> !multiturn_supply_alarm_n)
    else $error("supply low not flagged");
  a_supply_ok:
    assert property (!turnSupplyLow [*7] |-> multiturn_supply_alarm_n)
    else $error("supply alarm without cause");
  // the alarm register follows the take edge, so a back-to-back take shows one cycle later
  a_jump_set:
    assert property (take && big && seen_q |-> ##1 !position_jump_alarm_n)
    else $error("jump not flagged");
  a_jump_clear:
    assert property (take && !big && seen_q |-> ##1 position_jump_alarm_n)
    else $error("jump alarm not cleared");
  a_jump_cause:
    assert property ($changed(position_jump_alarm_n) |-> $past(take) || $past(take, 2))
    else $error("jump alarm moved alone");
  a_ready_cause:
    assert property ($fell(rawReady) |-> $past(rawValid))
    else $error("ready fell without write");
endmodule

bind ssi_absolute_encoder_port ssi_encoder_port_asserts #(.JUMP_LIMIT(JUMP_LIMIT))
  u_ssi_encoder_port_asserts (.clk_sys, .reset_n, .ssiLoopClk, .dataPos, .dataNeg,
  .turnSupplyLow, .rawWord, .rawValid, .rawReady, .position_jump_alarm_n,
  .multiturn_supply_alarm_n);

/* File: dv/ssi_master_model.sv */
// far-side master: clocks a frame and shifts the word in
`timescale 1ns/1ps
`include "ssi_encoder_params.svh"
module ssi_master_model (
  output logic ssiLoopClk,
  input wire logic dataPos,
  input wire logic dataNeg
);
  initial ssiLoopClk = 1'h1;
  // one edge past bit 0 must bring the line back to one
  task automatic readWord(output logic [`POS_W-1:0] w, output logic ok);
    ok = 1'h1;
    #7;
    for (int i = `POS_W - 1; i >= -1; i--)
    begin
      ssiLoopClk = 1'h0;
      #32;
      ssiLoopClk = 1'h1;
      ok &= dataNeg === !dataPos;
      if (i >= 0) w[i] = dataPos;
      else ok &= dataPos === 1'h1;
      #32;
    end
  endtask
endmodule

/* File: dv/ssi_absolute_encoder_port_tb.sv */
// self-checking bench for the serial absolute encoder port
`timescale 1ns/1ps
module ssi_absolute_encoder_port_tb
  import ssi_encoder_pkg::*;
();
  logic clk_sys = 1'h0;
  logic reset_n = 1'h0;
  logic zeroIn = 1'h0;
  logic dirIn = 1'h1;
  logic turnSupplyLow = 1'h0;
  logic rawValid = 1'h0;
  pos_word_t rawWord = '0;
  logic ssiLoopClk, dataPos, dataNeg, rawReady, jumpAlarm_n, supplyAlarm_n, ok;
  pos_word_t r;
  int nMismatch = 0;
  int cmpCount = 0;
  ssi_absolute_encoder_port #(.ZERO_MIN_CYC(50), .MONO_CYC(20)) u_ssi_absolute_encoder_port (
    .clk_sys, .reset_n, .ssiLoopClk, .dataPos, .dataNeg, .zeroIn, .dirIn, .turnSupplyLow,
    .rawWord, .rawValid, .rawReady, .position_jump_alarm_n(jumpAlarm_n),
    .multiturn_supply_alarm_n(supplyAlarm_n));
  ssi_master_model u_ssi_master_model (.ssiLoopClk, .dataPos, .dataNeg);
  initial
    forever #10 clk_sys = ~clk_sys;
  task automatic chk(input pos_word_t got, input pos_word_t exp);
    cmpCount++;
    if (got !== exp)
    begin
      nMismatch++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic endSim();
    $display("compares %0d mismatches %0d", cmpCount, nMismatch);
    if (nMismatch == 0 && cmpCount > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  task automatic push(input pos_word_t v);
    @(posedge clk_sys);
    rawValid <= 1'h1;
    rawWord <= v;
    do @(posedge clk_sys); while (rawReady !== 1'h1);
    rawValid <= 1'h0;
  endtask
  // a frame carries the word armed before it, so the first one after pushes is stale
  task automatic rd(input pos_word_t exp, input bit c);
    u_ssi_master_model.readWord(r, ok);
    if (c) chk(r, exp);
    chk(ok, 1'h1);
    repeat (40) @(posedge clk_sys);
  endtask
  task automatic pulse(input int n);
    @(posedge clk_sys);
    zeroIn <= 1'h1;
    repeat (n) @(posedge clk_sys);
    zeroIn <= 1'h0;
    repeat (5) @(posedge clk_sys);
  endtask
  task automatic pj(input pos_word_t v, input logic e);
    push(v);
    @(posedge clk_sys);
    #1 chk(jumpAlarm_n, e);
  endtask
  task automatic tFill();
    chk({dataPos, dataNeg, jumpAlarm_n, supplyAlarm_n}, 4'hb);
    for (int i = 0; i < 16; i++)
      push(25'ha00 + i);
    #1 chk(rawReady, 1'h0);
    @(posedge clk_sys);
    rawValid <= 1'h1;
    rawWord <= 25'h1ffffff;
    repeat (3) @(posedge clk_sys);
    rawValid <= 1'h0;
    rd('0, 1'h0);
    for (int i = 0; i < 17; i++)
      rd(25'ha00 + (i < 16 ? i : 15), 1'h1);
    $display("fifo test done");
  endtask
  task automatic tDir();
    @(posedge clk_sys);
    dirIn <= 1'h0;
    repeat (5) @(posedge clk_sys);
    push(25'h123);
    rd('0, 1'h0);
    rd(25'h1fffedd, 1'h1);
    $display("direction test done");
  endtask
  task automatic tZero();
    @(posedge clk_sys);
    dirIn <= 1'h1;
    repeat (5) @(posedge clk_sys);
    push(25'h400);
    pulse(30);
    push(25'h403);
    pulse(60);
    push(25'h408);
    rd('0, 1'h0);
    rd(25'h400, 1'h1);
    rd(25'h403, 1'h1);
    rd(25'h5, 1'h1);
    $display("zero test done");
  endtask
  task automatic tAlarm();
    pj(25'h508, 1'h1);
    pj(25'h609, 1'h0);
    pj(25'h60a, 1'h1);
    @(posedge clk_sys);
    turnSupplyLow <= 1'h1;
    repeat (8) @(posedge clk_sys);
    #1 chk(supplyAlarm_n, 1'h0);
    @(posedge clk_sys);
    turnSupplyLow <= 1'h0;
    repeat (8) @(posedge clk_sys);
    #1 chk(supplyAlarm_n, 1'h1);
    $display("alarm test done");
  endtask
  initial
  begin
    fork
      u_ssi_master_model.readWord(r, ok);
    join_none
    repeat (6) @(posedge clk_sys);
    reset_n <= 1'h1;
    repeat (150) @(posedge clk_sys);
    tFill();
    tDir();
    tZero();
    tAlarm();
    endSim();
  end
  initial
  begin
    #400000;
    nMismatch++;
    endSim();
  end
endmodule
